// file: hw/dcc_pkg.sv
// Shared constants, field positions and carrier types of the channel control block.
package dcc_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int          NUM_CHAN = 4;
  localparam int          CHAN_NUM = 1;
  localparam int          RANK_W   = 3;

  // ---------------------------------------------------------------------------
  // Register map: printed offsets, index is the low byte, byte address is 4 x index
  // ---------------------------------------------------------------------------
  localparam logic [31:0] OFS_SRC_LO  = 32'h5000_3610;
  localparam logic [31:0] OFS_SRC_HI  = 32'h5000_3612;
  localparam logic [31:0] OFS_DST_LO  = 32'h5000_3614;
  localparam logic [31:0] OFS_DST_HI  = 32'h5000_3616;
  localparam logic [31:0] OFS_THRESH  = 32'h5000_3618;
  localparam logic [31:0] OFS_LENGTH  = 32'h5000_361A;
  localparam logic [31:0] OFS_CONTROL = 32'h5000_361C;
  localparam logic [31:0] OFS_COUNTER = 32'h5000_361E;
  localparam logic [7:0]  IDX_SRC_LO  = OFS_SRC_LO[7:0];
  localparam logic [7:0]  IDX_SRC_HI  = OFS_SRC_HI[7:0];
  localparam logic [7:0]  IDX_DST_LO  = OFS_DST_LO[7:0];
  localparam logic [7:0]  IDX_DST_HI  = OFS_DST_HI[7:0];
  localparam logic [7:0]  IDX_THRESH  = OFS_THRESH[7:0];
  localparam logic [7:0]  IDX_LENGTH  = OFS_LENGTH[7:0];
  localparam logic [7:0]  IDX_CONTROL = OFS_CONTROL[7:0];
  localparam logic [7:0]  IDX_COUNTER = OFS_COUNTER[7:0];

  // ---------------------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------------------
  localparam int          CTL_RUN      = 0;
  localparam int          CTL_WIDTH    = 1;
  localparam int          CTL_IRQ_EN   = 3;
  localparam int          CTL_TRIG     = 4;
  localparam int          CTL_DST_STEP = 5;
  localparam int          CTL_SRC_STEP = 6;
  localparam int          CTL_CIRC     = 7;
  localparam int          CTL_RANK     = 8;
  localparam int          CTL_YIELD    = 11;
  localparam int          CTL_FILL     = 12;
  localparam int          CTL_SENSE    = 13;
  localparam logic [15:0] CTL_WMASK    = 16'h3FFF;
  localparam logic [15:0] RST_REG16    = 16'h0000;
  localparam logic [31:0] RST_REG32    = 32'h0000_0000;

  localparam logic [1:0]  WIDTH_1B     = 2'h0;
  localparam logic [1:0]  WIDTH_2B     = 2'h1;
  localparam logic [1:0]  WIDTH_4B     = 2'h2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef logic [RANK_W-1:0] dcc_rank_t;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_REQ, ST_ARB, ST_READ, ST_WRITE, ST_GAP} dcc_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dcc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dcc_wb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcc_mst_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } dcc_mst_rsp_t;

endpackage

// file: hw/dcc_arbiter.sv
// Rank arbiter between the DMA channels with hold for a locked owner.
`timescale 1ns/100ps
module dcc_arbiter
  import dcc_pkg::*;
(
  input  wire logic                          mclk_in,
  input  wire logic                          resetn_in,
  input  wire logic [NUM_CHAN-1:0]           req_in,
  input  wire dcc_rank_t [NUM_CHAN-1:0]      rank_in,
  input  wire logic                          lock_in,
  output logic      [NUM_CHAN-1:0]           grant_out
);

  typedef struct packed {
    logic       held_v;
    logic [1:0] held_id;
  } dcc_arb_state_t;

  dcc_arb_state_t r_reg;
  dcc_arb_state_t r_next;
  logic [1:0]     win;
  logic           found;
  dcc_rank_t      best;

  // ---------------------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    best  = '0;
    win   = 2'h0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      // Strict compare in ascending order keeps the lowest channel on a tie.
      if (req_in[i] && (!found || rank_in[i] > best)) begin
        found = 1'b1;
        best  = rank_in[i];
        win   = 2'(i);
      end
    end
    // A locked owner keeps the bus until it lets go.
    if (lock_in && r_reg.held_v && req_in[r_reg.held_id]) begin
      found = 1'b1;
      win   = r_reg.held_id;
    end
    grant_out      = found ? (NUM_CHAN'(1) << win) : '0;
    r_next.held_v  = found;
    r_next.held_id = win;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  a_grant_onehot: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    $onehot0(grant_out) && ((|req_in) == (|grant_out)))
    else $error("Arbiter grant is not one-hot or misses a request.");

endmodule

// file: hw/dcc_channel.sv
// Control, sequencing and register file of one DMA channel.
`timescale 1ns/100ps
//
// Functional notes
// - Bit 13 picks level or rising-edge requests.
// - Fill mode fetches once, writes everywhere.
// - Untriggered fill transfer holds bus against other channels.
// - Yield clear copies back to back, blocks.
// - Yield set inserts wait cycle after store.
// - Request-triggered mode ignores the yield bit.
// - Higher three-bit rank wins the bus.
// - Equal rank goes to lowest channel number.
// - Non-circular stops at length, clears run.
// - Circular triggered keeps run, restarts index.
// - Source step adds 1, 2 or 4.
// - Destination step adds 1, 2 or 4.
// - Bit 4 chooses immediate or request start.
// - Interrupt only while its enable bit set.
// - Width field sets item size, 11 reserved.
// - Run bit enables, hardware clears at end.
// - Read-only index forms addresses, zeroed at end.
// - Transfer moves length value plus one items.
// - Interrupt when threshold equals index after item.
// - Start addresses split in 16-bit halves.
module dcc_channel
  import dcc_pkg::*;
(
  input  wire logic                     mclk_in,
  input  wire logic                     resetn_in,
  input  wire dcc_wb_req_t              wb_req_in,
  output dcc_wb_rsp_t                   wb_rsp_out,
  input  wire logic                     dreq_in,
  input  wire logic [NUM_CHAN-1:0]      peer_req_in,
  input  wire dcc_rank_t [NUM_CHAN-1:0] peer_rank_in,
  output dcc_mst_req_t                  mst_req_out,
  input  wire dcc_mst_rsp_t             mst_rsp_in,
  output logic                          bus_hold_out,
  output logic                          irq_out,
  output logic                          own_req_out,
  output dcc_rank_t                     own_rank_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    dcc_state_t   st;
    logic [15:0]  src_lo;
    logic [15:0]  src_hi;
    logic [15:0]  dst_lo;
    logic [15:0]  dst_hi;
    logic [15:0]  thresh;
    logic [15:0]  len;
    logic [15:0]  ctrl;
    logic [15:0]  idx;
    logic [31:0]  data;
    dcc_mst_req_t mst;
    logic         req_s1;
    logic         req_s2;
    logic         req_s3;
    logic         req_pend;
    logic         irq;
    logic         wb_ack;
    logic [31:0]  wb_dat;
  } dcc_chan_state_t;

  dcc_chan_state_t r_reg;
  dcc_chan_state_t r_next;

  logic [NUM_CHAN-1:0]      req_all;
  dcc_rank_t [NUM_CHAN-1:0] rank_all;
  logic [NUM_CHAN-1:0]      grant;
  logic                     own_grant;
  logic                     arb_lock;
  logic                     req_rise;
  logic                     req_ready;
  logic                     wb_hit;
  logic                     item_done;
  logic                     last_item;
  logic [31:0]              src_start;
  logic [31:0]              dst_start;
  logic [31:0]              src_addr;
  logic [31:0]              dst_addr;
  logic [15:0]              wdat16;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Reserved width code steps like a byte so the address never jumps oddly.
  function automatic logic [1:0] width_shift(input logic [1:0] w);
    return (w == WIDTH_4B) ? 2'h2 : ((w == WIDTH_2B) ? 2'h1 : 2'h0);
  endfunction

  function automatic logic [31:0] step_addr(input logic [31:0] base, input logic en,
                                            input logic [15:0] idx, input logic [1:0] w);
    return en ? base + ({16'h0000, idx} << width_shift(w)) : base;
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                             input logic [1:0] sel);
    return {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------
  always_comb begin
    req_all           = peer_req_in;
    rank_all          = peer_rank_in;
    req_all[CHAN_NUM] = own_req_out;
    rank_all[CHAN_NUM] = own_rank_out;
  end

  dcc_arbiter u_arbiter (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .req_in    (req_all),
    .rank_in   (rank_all),
    .lock_in   (arb_lock),
    .grant_out (grant)
  );

  assign own_grant    = grant[CHAN_NUM];
  // A fill run keeps asking through its wait cycle, so no other channel slips in.
  assign own_req_out  = (r_reg.st == ST_ARB) || (r_reg.st == ST_READ) || (r_reg.st == ST_WRITE) ||
                        (r_reg.ctrl[CTL_FILL] && (r_reg.st == ST_GAP));
  assign own_rank_out = r_reg.ctrl[CTL_RANK +: RANK_W];
  // An item is never split; an untriggered fill run keeps the bus between items.
  assign arb_lock     = (r_reg.st == ST_READ) || (r_reg.st == ST_WRITE) ||
                        (r_reg.ctrl[CTL_FILL] && r_reg.ctrl[CTL_RUN] && r_reg.st != ST_IDLE);
  // Triggered mode disregards yield and so always blocks.
  assign bus_hold_out = own_grant && own_req_out && (r_reg.ctrl[CTL_TRIG] || !r_reg.ctrl[CTL_YIELD]);

  // ---------------------------------------------------------------------------
  // Request sensing and addresses
  // ---------------------------------------------------------------------------
  assign req_rise   = r_reg.req_s2 && !r_reg.req_s3;
  assign req_ready  = r_reg.ctrl[CTL_SENSE] ? r_reg.req_pend : r_reg.req_s2;
  assign wb_hit     = wb_req_in.cyc && wb_req_in.stb;
  assign item_done  = (r_reg.st == ST_WRITE) && mst_rsp_in.ack;
  assign last_item  = (r_reg.idx == r_reg.len);
  assign src_start  = {r_reg.src_hi, r_reg.src_lo};
  assign dst_start  = {r_reg.dst_hi, r_reg.dst_lo};
  assign src_addr   = step_addr(src_start, r_reg.ctrl[CTL_SRC_STEP], r_reg.idx, r_reg.ctrl[CTL_WIDTH +: 2]);
  assign dst_addr   = step_addr(dst_start, r_reg.ctrl[CTL_DST_STEP], r_reg.idx, r_reg.ctrl[CTL_WIDTH +: 2]);
  assign wdat16     = lane_merge(16'h0000, wb_req_in.dat[15:0], wb_req_in.sel[1:0]);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    r_next        = r_reg;
    r_next.irq    = 1'b0;
    r_next.req_s1 = dreq_in;
    r_next.req_s2 = r_reg.req_s1;
    r_next.req_s3 = r_reg.req_s2;

    case (r_reg.st)
      ST_IDLE: begin
        r_next.req_pend = 1'b0;
        if (r_reg.ctrl[CTL_RUN]) begin
          r_next.st = r_reg.ctrl[CTL_TRIG] ? ST_WAIT_REQ : ST_ARB;
        end
      end
      ST_WAIT_REQ: begin
        if (!r_reg.ctrl[CTL_RUN]) begin
          r_next.st = ST_IDLE;
        end else if (req_ready) begin
          r_next.req_pend = 1'b0;
          r_next.st       = ST_ARB;
        end
      end
      ST_ARB: begin
        if (!r_reg.ctrl[CTL_RUN]) begin
          r_next.st = ST_IDLE;
        end else if (own_grant) begin
          r_next.mst.valid = 1'b1;
          r_next.mst.size  = r_reg.ctrl[CTL_WIDTH +: 2];
          if (r_reg.ctrl[CTL_FILL] && r_reg.idx != 16'h0000) begin
            r_next.st        = ST_WRITE;
            r_next.mst.we    = 1'b1;
            r_next.mst.addr  = dst_addr;
            r_next.mst.wdata = r_reg.data;
          end else begin
            r_next.st       = ST_READ;
            r_next.mst.we   = 1'b0;
            r_next.mst.addr = src_addr;
          end
        end
      end
      ST_READ: begin
        if (mst_rsp_in.ack) begin
          r_next.data      = mst_rsp_in.rdata;
          r_next.st        = ST_WRITE;
          r_next.mst.we    = 1'b1;
          r_next.mst.addr  = dst_addr;
          r_next.mst.wdata = mst_rsp_in.rdata;
        end
      end
      ST_WRITE: begin
        if (mst_rsp_in.ack) begin
          r_next.mst.valid = 1'b0;
          r_next.mst.we    = 1'b0;
          // Compare before the index moves on.
          r_next.irq = r_reg.ctrl[CTL_IRQ_EN] && (r_reg.thresh == r_reg.idx);
          if (last_item) begin
            r_next.idx = 16'h0000;
            if (r_reg.ctrl[CTL_CIRC] && r_reg.ctrl[CTL_TRIG]) begin
              r_next.st = ST_WAIT_REQ;
            end else begin
              r_next.ctrl[CTL_RUN] = 1'b0;
              r_next.st            = ST_IDLE;
            end
          end else begin
            r_next.idx = r_reg.idx + 16'h0001;
            if (r_reg.ctrl[CTL_TRIG]) begin
              r_next.st = ST_WAIT_REQ;
            end else begin
              r_next.st = r_reg.ctrl[CTL_YIELD] ? ST_GAP : ST_ARB;
            end
          end
        end
      end
      ST_GAP: begin
        r_next.st = ST_ARB;
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase

    // Edges count only while running edge-sensed, so a stale edge cannot start a later run.
    // A fresh edge outranks the clear of the pending flag.
    if (req_rise && r_reg.ctrl[CTL_SENSE] && r_reg.ctrl[CTL_RUN]) begin
      r_next.req_pend = 1'b1;
    end

    // Register bus: read data is caught with ack, writes land on the acked edge.
    r_next.wb_ack = wb_hit && !r_reg.wb_ack;
    if (wb_hit && !r_reg.wb_ack) begin
      case (wb_req_in.adr[9:2])
        IDX_SRC_LO:  r_next.wb_dat = {16'h0000, r_reg.src_lo};
        IDX_SRC_HI:  r_next.wb_dat = {16'h0000, r_reg.src_hi};
        IDX_DST_LO:  r_next.wb_dat = {16'h0000, r_reg.dst_lo};
        IDX_DST_HI:  r_next.wb_dat = {16'h0000, r_reg.dst_hi};
        IDX_THRESH:  r_next.wb_dat = {16'h0000, r_reg.thresh};
        IDX_LENGTH:  r_next.wb_dat = {16'h0000, r_reg.len};
        IDX_CONTROL: r_next.wb_dat = {16'h0000, r_reg.ctrl & CTL_WMASK};
        IDX_COUNTER: r_next.wb_dat = {16'h0000, r_reg.idx};
        default:     r_next.wb_dat = RST_REG32;
      endcase
    end
    if (wb_hit && r_reg.wb_ack && wb_req_in.we) begin
      case (wb_req_in.adr[9:2])
        IDX_SRC_LO:  r_next.src_lo = lane_merge(r_reg.src_lo, wb_req_in.dat[15:0], wb_req_in.sel[1:0]);
        IDX_SRC_HI:  r_next.src_hi = lane_merge(r_reg.src_hi, wb_req_in.dat[15:0], wb_req_in.sel[1:0]);
        IDX_DST_LO:  r_next.dst_lo = lane_merge(r_reg.dst_lo, wb_req_in.dat[15:0], wb_req_in.sel[1:0]);
        IDX_DST_HI:  r_next.dst_hi = lane_merge(r_reg.dst_hi, wb_req_in.dat[15:0], wb_req_in.sel[1:0]);
        IDX_THRESH:  r_next.thresh = lane_merge(r_reg.thresh, wb_req_in.dat[15:0], wb_req_in.sel[1:0]);
        IDX_LENGTH:  r_next.len    = lane_merge(r_reg.len, wb_req_in.dat[15:0], wb_req_in.sel[1:0]);
        // Software write beats the hardware clear of the run bit in the same cycle.
        IDX_CONTROL: r_next.ctrl   = lane_merge(r_reg.ctrl, wdat16, wb_req_in.sel[1:0]) & CTL_WMASK;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign wb_rsp_out.ack = r_reg.wb_ack;
  assign wb_rsp_out.dat = r_reg.wb_dat;
  assign mst_req_out    = r_reg.mst;
  assign irq_out        = r_reg.irq;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_item_gap;
    (r_reg.st == ST_GAP) ##1 (r_reg.st == ST_ARB);
  endsequence

  a_level_start: assert property ((r_reg.st == ST_WAIT_REQ) && r_reg.ctrl[CTL_RUN] && !r_reg.ctrl[CTL_SENSE] &&
    r_reg.req_s2 && !(wb_hit && r_reg.wb_ack && wb_req_in.we) |=> (r_reg.st == ST_ARB))
    else $error("Level request did not start arbitration.");

  a_fill_skip: assert property ((r_reg.st == ST_ARB) && own_grant && r_reg.ctrl[CTL_RUN] && r_reg.ctrl[CTL_FILL] &&
    (r_reg.idx != 16'h0000) |=> (r_reg.st == ST_WRITE) && (r_reg.mst.wdata == $past(r_reg.data)))
    else $error("Fill item re-read its source.");

  a_fill_lock: assert property (r_reg.ctrl[CTL_FILL] && r_reg.ctrl[CTL_RUN] && own_grant &&
    !(wb_hit && r_reg.wb_ack && wb_req_in.we) |=> own_grant || !own_req_out)
    else $error("Fill transfer lost the bus to another channel.");

  a_block_hold: assert property ((r_reg.st == ST_READ) && own_grant && !r_reg.ctrl[CTL_YIELD] |-> bus_hold_out)
    else $error("Blocking copy did not hold the bus.");

  a_yield_gap: assert property (item_done && !last_item && !r_reg.ctrl[CTL_TRIG] && r_reg.ctrl[CTL_YIELD] &&
    !(wb_hit && r_reg.wb_ack && wb_req_in.we) |=> s_item_gap)
    else $error("Yield mode missed its wait cycle.");

  a_trig_nogap: assert property (item_done && r_reg.ctrl[CTL_TRIG] |=> (r_reg.st != ST_GAP))
    else $error("Triggered mode inserted a wait cycle.");

  a_stop_clear: assert property (item_done && last_item && !(r_reg.ctrl[CTL_CIRC] && r_reg.ctrl[CTL_TRIG]) &&
    !(wb_hit && r_reg.wb_ack && wb_req_in.we) |=> !r_reg.ctrl[CTL_RUN] && (r_reg.idx == 16'h0000))
    else $error("Run bit not cleared at end of transfer.");

  a_circ_keep: assert property (item_done && last_item && r_reg.ctrl[CTL_CIRC] && r_reg.ctrl[CTL_TRIG] &&
    !(wb_hit && r_reg.wb_ack && wb_req_in.we) |=> r_reg.ctrl[CTL_RUN] && (r_reg.st == ST_WAIT_REQ))
    else $error("Circular transfer did not restart.");

  a_src_fixed: assert property ($rose(r_reg.st == ST_READ) && !r_reg.ctrl[CTL_SRC_STEP] |-> (r_reg.mst.addr == src_start))
    else $error("Fixed source address moved.");

  a_irq_gate: assert property (item_done |=> (irq_out == ($past(r_reg.ctrl[CTL_IRQ_EN]) &&
    ($past(r_reg.thresh) == $past(r_reg.idx)))))
    else $error("Interrupt does not match threshold and enable.");

endmodule

// file: test/dcc_bus_model.sv
// Behavioural memory on the far side of the channel's master port.
`timescale 1ns/100ps
module dcc_bus_model
  import dcc_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         resetn_in,
  input  wire logic         slow_in,
  input  wire dcc_mst_req_t req_in,
  output dcc_mst_rsp_t      rsp_out
);
  logic [1:0] wait_cnt;
  // Read data is inverted on every cycle between answers, so stale data matches the last answer on every other cycle.
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wait_cnt <= 2'h0;
      rsp_out  <= '0;
    end else if (req_in.valid && !rsp_out.ack && (wait_cnt >= {slow_in, 1'b0})) begin
      wait_cnt      <= 2'h0;
      rsp_out.ack   <= 1'b1;
      rsp_out.rdata <= req_in.addr + 32'h1111_0000;
    end else begin
      wait_cnt      <= (req_in.valid && !rsp_out.ack) ? wait_cnt + 2'h1 : 2'h0;
      rsp_out.ack   <= 1'b0;
      rsp_out.rdata <= ~rsp_out.rdata;
    end
  end
endmodule

// file: test/dcc_channel_bench.sv
// Self-checking bench of the channel control block.
`timescale 1ns/100ps
module dcc_channel_bench;
  import dcc_pkg::*;
  localparam logic [31:0] SRC = 32'h2000_0100;
  localparam logic [31:0] DST = 32'h2000_0400;
  logic                     mclk_in   = 1'b0;
  logic                     resetn_in = 1'b0;
  dcc_wb_req_t              wb_req    = '0;
  dcc_wb_rsp_t              wb_rsp;
  logic                     dreq      = 1'b0;
  logic                     slow      = 1'b0;
  logic [NUM_CHAN-1:0]      peer_req  = '0;
  dcc_rank_t [NUM_CHAN-1:0] peer_rank = '0;
  dcc_mst_req_t             mst_req;
  dcc_mst_rsp_t             mst_rsp;
  logic                     bus_hold;
  logic                     irq;
  logic                     own_req;
  dcc_rank_t                own_rank;
  logic                     hold_seen = 1'b0;
  logic [1:0]               sz_seen   = 2'h0;
  logic [31:0]              wa[$];
  logic [31:0]              wd[$];
  logic [15:0]              q;
  int                       n_mismatch = 0;
  int                       n_tests = 0;
  int                       n_irq = 0;
  int                       n_rd = 0;

  always #50 mclk_in = ~mclk_in;

  dcc_channel dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .wb_req_in(wb_req), .wb_rsp_out(wb_rsp),
    .dreq_in(dreq), .peer_req_in(peer_req), .peer_rank_in(peer_rank), .mst_req_out(mst_req),
    .mst_rsp_in(mst_rsp), .bus_hold_out(bus_hold), .irq_out(irq), .own_req_out(own_req),
    .own_rank_out(own_rank));
  dcc_bus_model bus_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .slow_in(slow), .req_in(mst_req),
    .rsp_out(mst_rsp));

  // Completed beats are logged at the edge where the memory acknowledges them.
  always @(posedge mclk_in) begin
    if (irq === 1'b1) n_irq++;
    if (bus_hold === 1'b1) hold_seen = 1'b1;
    if (mst_req.valid === 1'b1 && mst_rsp.ack === 1'b1) begin
      if (mst_req.we === 1'b1) begin
        wa.push_back(mst_req.addr);
        sz_seen = mst_req.size;
        wd.push_back(mst_req.wdata);
      end else begin
        n_rd++;
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] d);
    @(posedge mclk_in);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {22'h0, idx, 2'h0}, sel: 4'hF, dat: {16'h0, d}};
    do begin
      @(posedge mclk_in);
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat[15:0];
    wb_req <= '0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, IDX_CONTROL, 16'h0);
      n++;
    end while (q[CTL_RUN] !== 1'b0 && n < 100);
    if (q[CTL_RUN] !== 1'b0) n_mismatch++;
  endtask

  task automatic start(input logic [15:0] len, input logic [15:0] thr, input logic [15:0] ctl);
    wa.delete();
    wd.delete();
    n_rd = 0;
    n_irq = 0;
    hold_seen = 1'b0;
    wb(1'b1, IDX_SRC_LO, SRC[15:0]);
    wb(1'b1, IDX_SRC_HI, SRC[31:16]);
    wb(1'b1, IDX_DST_LO, DST[15:0]);
    wb(1'b1, IDX_DST_HI, DST[31:16]);
    wb(1'b1, IDX_LENGTH, len);
    wb(1'b1, IDX_THRESH, thr);
    wb(1'b1, IDX_CONTROL, ctl);
  endtask

  task automatic s_regs();
    wb(1'b0, IDX_CONTROL, 16'h0);
    chk(q, 16'h0);
    wb(1'b1, IDX_CONTROL, 16'hFFFE);
    wb(1'b0, IDX_CONTROL, 16'h0);
    chk(q, 16'h3FFE);
    chk(own_rank, 3'h7);
    wb(1'b1, IDX_COUNTER, 16'h0055);
    wb(1'b0, IDX_COUNTER, 16'h0);
    chk(q, 16'h0);
    wb(1'b1, IDX_SRC_HI, 16'hBEEF);
    wb(1'b1, 8'h40, 16'h1234);
    wb(1'b0, 8'h40, 16'h0);
    chk(q, 16'h0);
    wb(1'b0, IDX_SRC_HI, 16'h0);
    chk(q, 16'hBEEF);
    wb(1'b1, IDX_CONTROL, 16'h0);
  endtask

  task automatic s_copy();
    start(16'h1, 16'h1, 16'h006B);
    wait_idle();
    chk(wa.size(), 2);
    chk(n_rd, 2);
    for (int i = 0; i < 2; i++) begin
      chk(wa[i], DST + 32'(2 * i));
      chk(wd[i][15:0], SRC[15:0] + 16'(2 * i));
    end
    chk(n_irq, 1);
    chk(sz_seen, WIDTH_2B);
    chk(hold_seen, 1'b1);
    wb(1'b0, IDX_COUNTER, 16'h0);
    chk(q, 16'h0);
  endtask

  task automatic s_fill();
    slow <= 1'b1;
    start(16'h2, 16'h1, 16'h1025);
    for (int n = 0; n < 200 && wa.size() == 0; n++) @(posedge mclk_in);
    peer_req <= 4'h4;
    peer_rank[2] <= 3'h7;
    wait_idle();
    peer_req <= 4'h0;
    slow <= 1'b0;
    chk(q[CTL_RUN], 1'b0);
    chk(n_rd, 1);
    chk(wa.size(), 3);
    for (int i = 0; i < 3; i++) begin
      chk(wa[i], DST + 32'(4 * i));
      chk(wd[i], SRC + 32'h1111_0000);
    end
    chk(hold_seen, 1'b1);
    chk(n_irq, 0);
    chk(sz_seen, WIDTH_4B);
  endtask

  task automatic s_trig();
    start(16'h0, 16'h1, 16'h0811);
    repeat (20) @(posedge mclk_in);
    chk(wa.size(), 0);
    dreq <= 1'b1;
    wait_idle();
    dreq <= 1'b0;
    chk(wa.size(), 1);
    chk(hold_seen, 1'b1);
  endtask

  task automatic s_circ();
    start(16'h0, 16'h1, 16'h20B1);
    dreq <= 1'b1;
    repeat (30) @(posedge mclk_in);
    chk(wa.size(), 1);
    dreq <= 1'b0;
    repeat (5) @(posedge mclk_in);
    dreq <= 1'b1;
    repeat (30) @(posedge mclk_in);
    chk(wa.size(), 2);
    chk(wa[1], DST);
    wb(1'b0, IDX_CONTROL, 16'h0);
    chk(q[CTL_RUN], 1'b1);
    wb(1'b1, IDX_CONTROL, 16'h0);
    dreq <= 1'b0;
  endtask

  task automatic s_arb();
    peer_req <= 4'h1;
    peer_rank[0] <= 3'h3;
    start(16'h1, 16'h1, 16'h0B81);
    repeat (15) @(posedge mclk_in);
    chk(wa.size(), 0);
    chk(own_req, 1'b1);
    peer_rank[0] <= 3'h2;
    wait_idle();
    peer_req <= 4'h0;
    chk(wa.size(), 2);
    chk(hold_seen, 1'b0);
    chk(q[CTL_RUN], 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(negedge mclk_in);
    chk({wb_rsp.ack, mst_req.valid, irq, bus_hold, own_req}, 5'h00);
    s_regs();
    s_copy();
    s_fill();
    s_trig();
    s_circ();
    s_arb();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
